// ---- logic/gl_led_gpio.sv ----
// six shared pins: gpio with level interrupts, or port status indicators
// assumes synchronous pin and status inputs, single-word AHB-Lite master
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
module gl_led_gpio #(
   parameter int unsigned STRETCH_CYC = gl_pkg::STRETCH_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // pins
   input wire logic [5:0] gpio_in,
   output logic [5:0] gpio_out,
   output logic [5:0] gpio_oe,
   // straps
   input wire logic [5:0] strap_led_en,
   input wire logic [1:0] strap_led_fun,
   input wire logic [5:0] strap_led_pol,
   // port status, index 0 is port 1, index 1 is port 2
   input wire logic [1:0] p_link,
   input wire logic [1:0] p_speed100,
   input wire logic [1:0] p_full_dup,
   input wire logic [1:0] p_collision,
   input wire logic [1:0] p_activity,
   input wire logic p0_tx,
   input wire logic p0_rx,
   // raw mii enables, index is port number
   input wire logic [2:0] mii_tx_en,
   input wire logic [2:0] mii_rx_dv,
   // interrupt request
   output logic pin_irq_event
);

   localparam int unsigned N = gl_pkg::NPIN;
   localparam int unsigned CW = $clog2(STRETCH_CYC + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(STRETCH_CYC - 1);
   localparam logic [CW-1:0] CNT_ZERO = '0;

   typedef struct packed {
      logic [5:0] pin_data_bits;
      logic [5:0] pin_direction_bits;
      logic [5:0] out_buffer_type_bits;
      logic [5:0] ipol;
      logic [5:0] ist;
      logic [5:0] ien;
      logic [5:0] led_en;
      logic [1:0] led_fun;
      logic [5:0] led_pol;
      logic loaded;
      logic wr_pend;
      logic [1:0] wr_idx;
      logic [31:0] rdata;
      gl_pkg::gl_str_t [5:0] ph;
      logic [5:0][CW-1:0] cnt;
      logic [5:0] pout;
      logic [5:0] poe;
   } gl_state_t;

   gl_state_t state_q, state_d;
   logic acc, map_ok;
   logic [5:0] in_mask, rd_pins, lvl_hit, w1c, act_v, raw_v;
   logic [5:0] ev_v, od_mask, pp_mask;
   logic [1:0] pos;
   logic lk, sp, base, gate, inv, pulse;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      state_d.wr_pend = 1'b0;
      acc = hsel & hready & htrans[1];
      map_ok = (haddr & gl_pkg::MAP_MASK) == 32'h0000_0000;
      w1c = 6'h00;
      act_v = 6'h00;
      raw_v = 6'h00;
      ev_v = 6'h00;
      pos = 2'h0;
      lk = 1'b0;
      sp = 1'b0;
      base = 1'b0;
      gate = 1'b1;
      inv = 1'b0;
      pulse = 1'b0;

      // indicator pins have their input buffer switched off
      in_mask = ~state_q.pin_direction_bits & ~state_q.led_en;
      rd_pins = (state_q.pin_data_bits & state_q.pin_direction_bits
                 & ~state_q.led_en)
                | (gpio_in & in_mask);
      lvl_hit = ~state_q.led_en & ~(gpio_in ^ state_q.ipol);
      od_mask = ~state_q.led_en & state_q.pin_direction_bits
                & state_q.out_buffer_type_bits;
      pp_mask = ~state_q.led_en & state_q.pin_direction_bits
                & ~state_q.out_buffer_type_bits;

      // write data phase
      if (state_q.wr_pend) begin
         case (state_q.wr_idx)
            2'h0: begin
               state_d.pin_data_bits = hwdata[5:0];
               state_d.pin_direction_bits =
                  hwdata[gl_pkg::HI_LSB +: 6];
            end
            2'h1: begin
               state_d.out_buffer_type_bits = hwdata[5:0];
               state_d.ipol = hwdata[gl_pkg::HI_LSB +: 6];
            end
            2'h2: begin
               w1c = hwdata[5:0];
               state_d.ien = hwdata[gl_pkg::HI_LSB +: 6];
            end
            2'h3: begin
               // polarity is not writable, only enable and select
               state_d.led_en = hwdata[5:0];
               state_d.led_fun = hwdata[gl_pkg::HI_LSB +: 2];
            end
            default: begin
            end
         endcase
      end

      // level source keeps setting; a set beats a same-cycle clear
      state_d.ist = (state_q.ist & ~w1c) | lvl_hit;

      // straps caught on the first cycle after reset release
      if (!state_q.loaded) begin
         state_d.led_en = strap_led_en;
         state_d.led_fun = strap_led_fun;
         state_d.led_pol = strap_led_pol;
         state_d.loaded = 1'b1;
      end

      // address phase
      if (acc) begin
         state_d.wr_pend = hwrite & map_ok;
         state_d.wr_idx = haddr[3:2];
         state_d.rdata = 32'h0000_0000;
         if (!hwrite && map_ok) begin
            case (haddr[3:2])
               2'h0: begin
                  state_d.rdata[5:0] = rd_pins;
                  state_d.rdata[gl_pkg::HI_LSB +: 6] =
                     state_q.pin_direction_bits;
               end
               2'h1: begin
                  state_d.rdata[5:0] = state_q.out_buffer_type_bits;
                  state_d.rdata[gl_pkg::HI_LSB +: 6] = state_q.ipol;
               end
               2'h2: begin
                  state_d.rdata[5:0] = state_q.ist;
                  state_d.rdata[gl_pkg::HI_LSB +: 6] = state_q.ien;
               end
               2'h3: begin
                  state_d.rdata[5:0] = state_q.led_en;
                  state_d.rdata[gl_pkg::HI_LSB +: 2] = state_q.led_fun;
                  state_d.rdata[gl_pkg::LPOL_LSB +: 6] =
                     state_q.led_pol;
               end
               default: begin
               end
            endcase
         end
      end

      ////////////////////////////////////////////////////////////////
      // pins 5..3 follow port 2, pins 2..0 port 1
      for (int i = 0; i < N; i++) begin
         pos = 2'(i % 3);
         lk = p_link[i / 3];
         sp = p_speed100[i / 3];
         base = 1'b0;
         gate = 1'b1;
         inv = 1'b0;
         case (state_q.led_fun)
            gl_pkg::FUN_LINK, gl_pkg::FUN_SPLIT: begin
               if (pos == 2'h1) begin
                  // full duplex steady, collisions only in half
                  base = lk & p_full_dup[i / 3];
                  ev_v[i] = lk & ~p_full_dup[i / 3]
                            & p_collision[i / 3];
                  gate = lk;
               end else begin
                  inv = 1'b1;
                  if (state_q.led_fun == gl_pkg::FUN_LINK) begin
                     base = (pos == 2'h2) ? lk : 1'b0;
                  end else if (pos == 2'h2) begin
                     base = lk & sp;
                  end else begin
                     base = lk & ~sp;
                  end
                  ev_v[i] = base & p_activity[i / 3];
                  if (state_q.led_fun == gl_pkg::FUN_LINK
                      && pos == 2'h0) begin
                     inv = 1'b0;
                     gate = lk & sp;
                     base = lk & sp;
                     ev_v[i] = 1'b0;
                  end
               end
            end
            gl_pkg::FUN_TRAF: begin
               if (pos == 2'h2) begin
                  // link state plays no part here
                  ev_v[i] = (i / 3 == 1) ? p0_tx : p0_rx;
               end else if (pos == 2'h1) begin
                  inv = 1'b1;
                  base = lk;
                  ev_v[i] = lk & p_activity[i / 3];
               end else begin
                  base = lk & sp;
                  gate = lk & sp;
               end
            end
            default: begin
            end
         endcase
         // one stretch timer per pin
         case (state_q.ph[i])
            gl_pkg::ST_IDLE: begin
               if (ev_v[i]) begin
                  state_d.ph[i] = gl_pkg::ST_PULSE;
                  state_d.cnt[i] = CNT_LOAD;
               end
            end
            gl_pkg::ST_PULSE: begin
               if (state_q.cnt[i] == CNT_ZERO) begin
                  state_d.ph[i] = gl_pkg::ST_GAP;
                  state_d.cnt[i] = CNT_LOAD;
               end else begin
                  state_d.cnt[i] = state_q.cnt[i] - CW'(1);
               end
            end
            gl_pkg::ST_GAP: begin
               // events in the gap are dropped: minimum rest time
               if (state_q.cnt[i] == CNT_ZERO) begin
                  state_d.ph[i] = gl_pkg::ST_IDLE;
               end else begin
                  state_d.cnt[i] = state_q.cnt[i] - CW'(1);
               end
            end
            default: begin
               state_d.ph[i] = gl_pkg::ST_IDLE;
            end
         endcase
         pulse = state_q.ph[i] == gl_pkg::ST_PULSE;
         act_v[i] = inv ? (base & ~pulse)
                        : ((base | pulse) & gate);
      end

      raw_v = {mii_tx_en[0], mii_tx_en[2], mii_rx_dv[2],
               mii_rx_dv[0], mii_tx_en[1], mii_rx_dv[1]};

      // pin drivers, registered
      for (int i = 0; i < N; i++) begin
         if (state_q.led_en[i]) begin
            if (state_q.led_fun == gl_pkg::FUN_RAW) begin
               state_d.poe[i] = 1'b1;
               state_d.pout[i] = raw_v[i];
            end else begin
               state_d.poe[i] = act_v[i];
               state_d.pout[i] = ~state_q.led_pol[i];
            end
         end else if (state_q.pin_direction_bits[i]) begin
            if (state_q.out_buffer_type_bits[i]) begin
               state_d.poe[i] = ~state_q.pin_data_bits[i];
               state_d.pout[i] = 1'b0;
            end else begin
               state_d.poe[i] = 1'b1;
               state_d.pout[i] = state_q.pin_data_bits[i];
            end
         end else begin
            state_d.poe[i] = 1'b0;
            state_d.pout[i] = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= '0;
         state_q.pin_direction_bits <= gl_pkg::RST_DIR;
         state_q.ien <= gl_pkg::RST_IEN;
         state_q.ipol <= gl_pkg::RST_IPOL;
         state_q.led_en <= gl_pkg::RST_ZERO;
         state_q.poe <= gl_pkg::RST_ZERO;
      end else begin
         state_q <= state_d;
      end
   end

   assign hrdata = state_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign gpio_out = state_q.pout;
   assign gpio_oe = state_q.poe;
   assign pin_irq_event = |(state_q.ist & state_q.ien);

   ////////////////////////////////////////////////////////////////////
   logic rd_data, rd_ind;
   assign rd_data = acc & ~hwrite & (haddr == gl_pkg::OFF_DATA);
   assign rd_ind = acc & ~hwrite & (haddr == gl_pkg::OFF_IND);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_reset_clears_cfg:
   assert property (rst_n && !$past(rst_n) |->
      state_q.pin_direction_bits == 6'h00 && state_q.ien == 6'h00
      && state_q.ipol == 6'h00)
   else $error("config not cleared by reset");

   a_opendrain_drive:
   assert property (((gpio_oe ^ ~$past(state_q.pin_data_bits))
      & $past(od_mask)) == 6'h00 && (gpio_out & $past(od_mask)) == 6'h00)
   else $error("open-drain pin drive wrong");

   a_pushpull_drive:
   assert property ((gpio_oe & $past(pp_mask)) == $past(pp_mask)
      && ((gpio_out ^ $past(state_q.pin_data_bits))
      & $past(pp_mask)) == 6'h00)
   else $error("push-pull pin drive wrong");

   a_input_read:
   assert property (rd_data |=> ((hrdata[5:0] ^ $past(gpio_in))
      & $past(in_mask)) == 6'h00 && (gpio_oe & $past(in_mask)) == 6'h00)
   else $error("input pin read or float wrong");

   a_level_sets:
   assert property ((state_q.ist & $past(lvl_hit)) == $past(lvl_hit))
   else $error("level did not set status");

   a_irq_request:
   assert property ((|(lvl_hit & state_q.ien)) ##1 $stable(state_q.ien)
      |-> pin_irq_event)
   else $error("enabled status gave no request");

   a_w1c_clears:
   assert property ((|(w1c & ~lvl_hit)) |=>
      (state_q.ist & $past(w1c) & ~$past(lvl_hit)) == 6'h00)
   else $error("write one did not clear status");

   a_strap_load:
   assert property (rst_n && !state_q.loaded |=>
      state_q.led_en == $past(strap_led_en)
      && state_q.led_fun == $past(strap_led_fun))
   else $error("strap defaults not loaded");

   a_polarity_fixed:
   assert property (state_q.loaded && $past(state_q.loaded) |->
      $stable(state_q.led_pol))
   else $error("indicator polarity changed");

   a_raw_follow:
   assert property (state_q.led_en[0] && state_q.led_fun == 2'h3 |=>
      gpio_oe[0] && gpio_out[0] == $past(mii_rx_dv[1]))
   else $error("raw indicator not followed");

   a_ind_active:
   assert property (state_q.led_en[3] && state_q.led_fun != 2'h3 |=>
      gpio_oe[3] == $past(act_v[3])
      && (!gpio_oe[3] || gpio_out[3] == !state_q.led_pol[3]))
   else $error("indicator drive level wrong");

   a_speed_map:
   assert property (state_q.led_fun == 2'h0 |->
      act_v[0] == (p_link[0] & p_speed100[0]))
   else $error("speed indicator wrong");

   a_read_ind:
   assert property (rd_ind |=> hrdata[9:8] == $past(state_q.led_fun))
   else $error("select readback wrong");

   for (genvar g = 0; g < N; g++) begin : g_chk
      sequence s_idle;
         state_q.ph[g] == gl_pkg::ST_IDLE && ev_v[g];
      endsequence
      sequence s_end_pulse;
         state_q.ph[g] == gl_pkg::ST_PULSE && state_q.cnt[g] == CNT_ZERO;
      endsequence
      a_pulse_load:
      assert property (s_idle |=> state_q.ph[g] == gl_pkg::ST_PULSE
         && state_q.cnt[g] == CNT_LOAD)
      else $error("stretch pulse start wrong");
      a_gap_load:
      assert property (s_end_pulse |=> state_q.ph[g] == gl_pkg::ST_GAP
         && state_q.cnt[g] == CNT_LOAD)
      else $error("stretch gap start wrong");
   end

endmodule // gl_led_gpio

// ---- logic/gl_pkg.sv ----
// constants and types of the shared gpio / status indicator pin block
// assumes one 250 MHz clock, synchronous reset, AHB-Lite register access
//
// Overview of operation
// - six pins: input, push-pull, open-drain, interrupt
// - reset clears direction, interrupt enable, polarity
// - buffer type bit picks push-pull or open-drain
// - open-drain drives low on 0, floats on 1
// - push-pull drives pin to its data bit
// - input pin data bit reads pin level
// - status and enable per pin, one request
// - polarity set: high sets status, else low
// - indicator enable makes pin output, input off
// - indicator defaults loaded from straps
// - select 00/01 maps link, duplex, speed per port
// - select 10/11 maps traffic or raw enables
// - active drives inverse strap polarity, else float
// - indicator polarity fixed by latched strap
// - port 0 traffic pulses 80 ms, 80 ms gap
// - link/activity blinks inactive 80 ms on traffic
// - duplex steady, collision pulses, off without link
// - speed active at 100, off at 10 or down
// - 100 link/activity only at 100 with link
// - 10 link/activity only at 10 with link
// - raw select drives push-pull, ignores polarity
package gl_pkg;

   localparam int unsigned NPIN = 6;

   // register byte offsets
   localparam logic [31:0] OFF_DATA = 32'h0000_0000;
   localparam logic [31:0] OFF_CFG = 32'h0000_0004;
   localparam logic [31:0] OFF_IRQ = 32'h0000_0008;
   localparam logic [31:0] OFF_IND = 32'h0000_000C;
   localparam logic [31:0] MAP_MASK = 32'hFFFF_FFF3;

   // field positions: low field at bit 0, second field here
   localparam int unsigned HI_LSB = 8;
   localparam int unsigned LPOL_LSB = 16;

   // values after reset
   localparam logic [5:0] RST_DIR = 6'h00;
   localparam logic [5:0] RST_IEN = 6'h00;
   localparam logic [5:0] RST_IPOL = 6'h00;
   localparam logic [5:0] RST_ZERO = 6'h00;

   // indicator function selects
   localparam logic [1:0] FUN_LINK = 2'h0;
   localparam logic [1:0] FUN_SPLIT = 2'h1;
   localparam logic [1:0] FUN_TRAF = 2'h2;
   localparam logic [1:0] FUN_RAW = 2'h3;

   // stretch interval
   localparam int unsigned STRETCH_MS = 80;
   localparam int unsigned CLK_KHZ = 250000;
   localparam int unsigned STRETCH_CYC = STRETCH_MS * CLK_KHZ;

   typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_GAP} gl_str_t;

endpackage

// ---- bench/gl_pin_model.sv ----
// board side of the six shared pins: pull-ups and an optional driver
// assumes the bench changes ext_en and ext_val just after a rising edge
module gl_pin_model (
   // from the block
   input wire logic [5:0] gpio_out,
   input wire logic [5:0] gpio_oe,
   // external driver
   input wire logic [5:0] ext_en,
   input wire logic [5:0] ext_val,
   // resolved pin level
   output logic [5:0] pin_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   // a pin released by the block and the external driver settles at the pull-up level, never the last value
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pin_lvl[i] = gpio_oe[i] ? gpio_out[i] :
            (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule // gl_pin_model

// ---- bench/tb_top.sv ----
// self-checking bench of the shared gpio / status indicator block
// assumes a shortened stretch interval and a zero-wait bus slave
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STR = 8;
   logic mclk = 1'b0;
   logic rst_n, hsel, hwrite, hreadyout, hresp, pin_irq_event, p0_tx, p0_rx;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, strap_led_fun, p_link, p_speed100, p_full_dup;
   logic [1:0] p_collision, p_activity;
   logic [2:0] hsize, mii_tx_en, mii_rx_dv;
   logic [5:0] gpio_out, gpio_oe, pin_lvl, ext_en, ext_val;
   logic [5:0] strap_led_en, strap_led_pol, pol, en, v, act;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int seed = 32'hC4B97744;
   int n;

   always #2 mclk = ~mclk;

   gl_led_gpio #(.STRETCH_CYC(STR)) gl_led_gpio_i (.mclk(mclk),
      .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .gpio_in(pin_lvl), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .strap_led_en(strap_led_en), .strap_led_fun(strap_led_fun),
      .strap_led_pol(strap_led_pol), .p_link(p_link),
      .p_speed100(p_speed100), .p_full_dup(p_full_dup),
      .p_collision(p_collision), .p_activity(p_activity), .p0_tx(p0_tx),
      .p0_rx(p0_rx), .mii_tx_en(mii_tx_en), .mii_rx_dv(mii_rx_dv),
      .pin_irq_event(pin_irq_event));

   gl_pin_model gl_pin_model_i (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic chk_pin(input logic [5:0] exp, input logic [5:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t pin exp=%h got=%h", $time, exp, got);
      end
   endtask

   // single word transfer; waits on hready, never assumes a latency
   task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   // length of the next run of one drive-enable level on a pin
   task automatic run_len(input int idx, input logic lvl, output int m);
      int k;
      k = 0;
      m = 0;
      @(negedge mclk);
      while (gpio_oe[idx] !== lvl && k < 50) begin
         @(negedge mclk);
         k++;
      end
      while (gpio_oe[idx] === lvl && m < 50) begin
         @(negedge mclk);
         m++;
      end
   endtask

   task automatic stretch(input int idx, input logic lvl);
      run_len(idx, lvl, n);
      chk_reg(32'(STR), 32'(n));
      run_len(idx, ~lvl, n);
      chk_reg(32'h1, {31'h0, n >= STR});
   endtask

   // expected active pins for a function select, raw levels for select 3
   function automatic logic [5:0] ind_act(input logic [1:0] f);
      logic [1:0] la, dc, sp, lt;
      la = p_link;
      dc = p_link & p_full_dup;
      sp = p_link & p_speed100;
      lt = p_link & ~p_speed100;
      case (f)
         2'h0: ind_act = {la[1], dc[1], sp[1], la[0], dc[0], sp[0]};
         2'h1: ind_act = {sp[1], dc[1], lt[1], sp[0], dc[0], lt[0]};
         2'h2: ind_act = {1'b0, la[1], sp[1], 1'b0, la[0], sp[0]};
         default: ind_act = {mii_tx_en[0], mii_tx_en[2], mii_rx_dv[2],
            mii_rx_dv[0], mii_tx_en[1], mii_rx_dv[1]};
      endcase
   endfunction

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      hsel = 1'b1;
      hsize = 3'h2;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      ext_en = 6'h00;
      ext_val = 6'h00;
      {p_link, p_speed100, p_full_dup, p_collision, p_activity} = 10'h000;
      {p0_tx, p0_rx, mii_tx_en, mii_rx_dv} = 8'h00;
      strap_led_en = 6'($random(seed));
      strap_led_fun = 2'($random(seed));
      strap_led_pol = 6'($random(seed));
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      xfer(1'b0, gl_pkg::OFF_DATA, 32'h0, rd);
      chk_reg(32'h0, rd & 32'h0000_3F00);
      xfer(1'b0, gl_pkg::OFF_CFG, 32'h0, rd);
      chk_reg(32'h0, rd & 32'h0000_3F00);
      xfer(1'b0, gl_pkg::OFF_IRQ, 32'h0, rd);
      chk_reg(32'h0, rd & 32'h0000_3F00);
      xfer(1'b0, gl_pkg::OFF_IND, 32'h0, rd);
      chk_reg({10'h0, strap_led_pol, 6'h0, strap_led_fun, 2'h0,
         strap_led_en}, rd);
      xfer(1'b1, gl_pkg::OFF_IND, 32'h003F_0000, rd);
      xfer(1'b0, gl_pkg::OFF_IND, 32'h0, rd);
      chk_reg({10'h0, strap_led_pol, 16'h0}, rd);
      xfer(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, rd);
      xfer(1'b0, 32'h0000_0010, 32'h0, rd);
      chk_reg(32'h0, rd);
      chk_reg(32'h0, {31'h0, hresp});
      // push-pull on even passes, open-drain on odd ones
      for (int k = 0; k < 4; k++) begin
         v = 6'($random(seed));
         xfer(1'b1, gl_pkg::OFF_CFG, {26'h0, {6{k[0]}}}, rd);
         xfer(1'b1, gl_pkg::OFF_DATA, {18'h0, 6'h3F, 2'h0, v}, rd);
         repeat (3) @(posedge mclk);
         @(negedge mclk);
         if (k[0]) begin
            chk_pin(~v, gpio_oe);
            chk_pin(v, pin_lvl);
         end else begin
            chk_pin(6'h3F, gpio_oe);
            chk_pin(v, gpio_out);
         end
         xfer(1'b0, gl_pkg::OFF_DATA, 32'h0, rd);
         chk_reg({18'h0, 6'h3F, 2'h0, v}, rd);
      end
      xfer(1'b1, gl_pkg::OFF_DATA, 32'h0, rd);
      // inputs and level interrupts
      for (int k = 0; k < 3; k++) begin
         pol = 6'($random(seed));
         en = 6'($random(seed));
         v = 6'($random(seed));
         ext_en <= 6'h3F;
         ext_val <= ~pol;
         xfer(1'b1, gl_pkg::OFF_CFG, {18'h0, pol, 8'h0}, rd);
         repeat (4) @(posedge mclk);
         xfer(1'b1, gl_pkg::OFF_IRQ, {18'h0, en, 8'h3F}, rd);
         xfer(1'b0, gl_pkg::OFF_IRQ, 32'h0, rd);
         chk_reg({18'h0, en, 8'h0}, rd);
         ext_val <= v;
         repeat (4) @(posedge mclk);
         xfer(1'b0, gl_pkg::OFF_DATA, 32'h0, rd);
         chk_reg({26'h0, v}, rd);
         act = ~(v ^ pol);
         ext_val <= ~pol;
         repeat (4) @(posedge mclk);
         xfer(1'b0, gl_pkg::OFF_IRQ, 32'h0, rd);
         chk_reg({18'h0, en, 2'h0, act}, rd);
         @(negedge mclk);
         chk_pin({5'h0, |(act & en)}, {5'h0, pin_irq_event});
         xfer(1'b1, gl_pkg::OFF_IRQ, {18'h0, en, 8'h3F}, rd);
         xfer(1'b0, gl_pkg::OFF_IRQ, 32'h0, rd);
         chk_reg({18'h0, en, 8'h0}, rd);
      end
      ext_en <= 6'h00;
      // indicators without traffic: two status sets per select
      for (int k = 0; k < 8; k++) begin
         @(posedge mclk);
         {p_link, p_speed100, p_full_dup} <= 6'($random(seed));
         {mii_tx_en, mii_rx_dv} <= 6'($random(seed));
         xfer(1'b1, gl_pkg::OFF_IND, {22'h0, 2'(k >> 1), 8'h3F}, rd);
         repeat (3) @(posedge mclk);
         @(negedge mclk);
         act = ind_act(2'(k >> 1));
         if ((k >> 1) == 3) begin
            chk_pin(6'h3F, gpio_oe);
            chk_pin(act, gpio_out);
         end else begin
            chk_pin(act, gpio_oe);
            chk_pin(~strap_led_pol & act, gpio_out & gpio_oe);
         end
      end
      xfer(1'b0, gl_pkg::OFF_DATA, 32'h0, rd);
      chk_reg(32'h0, rd & 32'h0000_003F);
      // stretched pulses with the cause held on
      @(posedge mclk);
      {p_link, p_speed100, p_full_dup} <= 6'h10;
      xfer(1'b1, gl_pkg::OFF_IND, 32'h0000_003F, rd);
      repeat (3) @(posedge mclk);
      p_activity <= 2'h1;
      stretch(2, 1'b0);
      @(posedge mclk);
      p_activity <= 2'h0;
      p_collision <= 2'h1;
      stretch(1, 1'b1);
      @(posedge mclk);
      p_collision <= 2'h0;
      p_link <= 2'h0;
      xfer(1'b1, gl_pkg::OFF_IND, 32'h0000_023F, rd);
      repeat (3) @(posedge mclk);
      p0_tx <= 1'b1;
      stretch(5, 1'b1);
      summarize();
   end
endmodule // tb_top
